// [logic/occ_clock_config.sv]
`timescale 1ns/1ps
//Operation
// R1: pll lock bit 5 reads 1 when locked or start-up timer expired.
// R2: clock fail bit 3 set by fail monitor, cleared by software.
// R3: writing 1 to clock fail acts as failure, raising fail trap.
// R4: secondary oscillator enable bit 1 turns that oscillator on or off.
// R5: switch request bit 0 starts switch to new source, clears when done.
// R6: software passes through fast rc between the two pll modes.
// R7: oscillator control writes need an unlock; locked writes are rejected.
// R8: four registers reset only on power-on reset.
// R9: recover-on-interrupt makes any interrupt clear slowdown enable.
// R10: slowdown ratio bits 14:12 divide by 2^code, reset 011.
// R11: slowdown enable applies the ratio, otherwise ratio is 1:1.
// R12: ratio writes are ignored while slowdown is enabled.
// R13: setting slowdown enable is ignored while ratio is 000.
// R14: fast rc postscale bits 10:8 divide by 2^code, 111 means 256.
// R15: vco divider bits 7:6: 2, 4, reserved, 8; reset 01.
// R16: nine-bit feedback gives multiplier value plus two, reset 50.
// R17: reference output enable bit 15 drives divided clock to pin.
// R18: reference sleep-run bit 13 keeps output running in sleep.
// R19: reference source bit 12 picks crystal when 1, system clock when 0.
// R20: reference divider four bits divide by 2^code up to 32768; the code toggles the pin every 2^code source edges and holds it high at code 0.
// R21: software clears reference enable before changing its divider.
// R22: pll prescale bits 4:0 divide input by value plus two.
// R23: new source codes: frc, frc pll, pri, pri pll, sec, lprc, frc16, frcn.
// R24: on switch completion current source takes new source, request clears.
// R25: unlock opens a window for exactly one oscillator control write.
module occ_clock_config
  import occ_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic sys_reset_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  input wire logic pll_locked_i,
  input wire logic clock_fail_i,
  input wire logic interrupt_i,
  input wire logic sleep_i,
  input wire logic crystal_clk_i,
  output logic osc_fail_trap_o,
  output logic secondary_osc_on_o,
  output logic [2:0] active_source_o,
  output logic cpu_slow_tick_o,
  output logic [2:0] fast_rc_postscale_o,
  output logic [1:0] vco_output_divider_o,
  output logic [4:0] pll_input_prescale_o,
  output logic [8:0] pll_feedback_multiplier_o,
  output logic [5:0] rc_trim_o,
  output logic reference_clock_pin_o
);
  // =====================================================================
  // reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [2:0] lock_sync_q;
  logic [2:0] fail_sync_q;
  logic [2:0] xtal_sync_q;
  logic lock_level_q;
  logic fail_level_q;
  logic fail_level_prev_q;
  logic xtal_level_q;
  logic xtal_prev_q;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // a level only changes once the second and third stage agree
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_sync_q <= 3'h0;
      fail_sync_q <= 3'h0;
      xtal_sync_q <= 3'h0;
      lock_level_q <= 1'b0;
      fail_level_q <= 1'b0;
      fail_level_prev_q <= 1'b0;
      xtal_level_q <= 1'b0;
      xtal_prev_q <= 1'b0;
    end else begin
      lock_sync_q <= {lock_sync_q[1:0], pll_locked_i};
      fail_sync_q <= {fail_sync_q[1:0], clock_fail_i};
      xtal_sync_q <= {xtal_sync_q[1:0], crystal_clk_i};
      if (lock_sync_q[1] == lock_sync_q[2]) begin
        lock_level_q <= lock_sync_q[2];
      end
      if (fail_sync_q[1] == fail_sync_q[2]) begin
        fail_level_q <= fail_sync_q[2];
      end
      if (xtal_sync_q[1] == xtal_sync_q[2]) begin
        xtal_level_q <= xtal_sync_q[2];
      end
      fail_level_prev_q <= fail_level_q;
      xtal_prev_q <= xtal_level_q;
    end
  end

  // =====================================================================
  // register write decode
  logic unlock_q;
  logic osc_wr;
  logic div_wr;
  logic fail_event;

  assign osc_wr = reg_write_i && reg_addr_i == OCC_ADDR_OSC_CTRL && unlock_q; // R7
  assign div_wr = reg_write_i && reg_addr_i == OCC_ADDR_CLK_DIV;
  assign fail_event = (fail_level_q && !fail_level_prev_q)
      || (osc_wr && reg_wdata_i[OCC_CLK_FAIL_BIT]); // R3

  // one accepted write per unlock; any oscillator control write closes it
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      unlock_q <= 1'b0;
    end else if (reg_write_i && reg_addr_i == OCC_ADDR_UNLOCK) begin
      unlock_q <= reg_wdata_i == OCC_UNLOCK_KEY; // R25
    end else if (reg_write_i && reg_addr_i == OCC_ADDR_OSC_CTRL) begin
      unlock_q <= 1'b0; // R25
    end
  end

  // =====================================================================
  // oscillator control: power-on reset only
  logic [2:0] new_src_q;
  logic [2:0] cur_src_q;
  logic sec_osc_q;
  logic switch_q;
  logic clk_fail_q;
  logic switch_done;
  occ_sw_state_type sw_state_q;
  logic [7:0] sw_count_q;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      new_src_q <= OCC_SRC_RESET; // R8
      sec_osc_q <= 1'b0;
    end else if (osc_wr) begin
      new_src_q <= reg_wdata_i[OCC_NEW_SRC_LSB +: 3]; // R23
      sec_osc_q <= reg_wdata_i[OCC_SEC_OSC_BIT]; // R4
    end
  end

  // hardware set wins over the software clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      clk_fail_q <= 1'b0;
    end else if (fail_event) begin
      clk_fail_q <= 1'b1; // R2
    end else if (osc_wr && !reg_wdata_i[OCC_CLK_FAIL_BIT]) begin
      clk_fail_q <= 1'b0; // R2
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_fail_trap_o <= 1'b0;
    end else begin
      osc_fail_trap_o <= fail_event; // R3
    end
  end

  // switch settles for a fixed time; rollover onto the new source
  assign switch_done = sw_state_q == OCC_SW_WAIT && sw_count_q == 8'h00;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sw_state_q <= OCC_SW_IDLE;
      sw_count_q <= 8'h00;
      switch_q <= 1'b0;
      cur_src_q <= OCC_SRC_RESET;
    end else begin
      case (sw_state_q)
        OCC_SW_IDLE: begin
          if (osc_wr && reg_wdata_i[OCC_SWITCH_BIT]) begin
            switch_q <= 1'b1; // R5
            sw_count_q <= 8'(OCC_SWITCH_CYC - 1);
            sw_state_q <= OCC_SW_WAIT;
          end
        end
        OCC_SW_WAIT: begin
          if (switch_done) begin
            cur_src_q <= new_src_q; // R24
            switch_q <= 1'b0; // R24
            sw_state_q <= OCC_SW_IDLE;
          end else begin
            sw_count_q <= sw_count_q - 8'h01;
          end
        end
        default: sw_state_q <= OCC_SW_IDLE;
      endcase
    end
  end

  // lock reads 0 while pll is unused, or while the start-up timer runs and the pll is not locked
  logic pll_used;
  logic [7:0] pll_timer_q;
  logic pll_lock_q;
  assign pll_used = cur_src_q == OCC_SRC_FRC_PLL || cur_src_q == OCC_SRC_PRI_PLL;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pll_timer_q <= 8'h00;
      pll_lock_q <= 1'b0;
    end else if (!pll_used) begin
      pll_timer_q <= 8'h00;
      pll_lock_q <= 1'b0; // R1
    end else begin
      if (pll_timer_q != 8'(OCC_PLL_START_CYC)) begin
        pll_timer_q <= pll_timer_q + 8'h01;
      end
      pll_lock_q <= lock_level_q || pll_timer_q == 8'(OCC_PLL_START_CYC); // R1
    end
  end

  // =====================================================================
  // clock divisor, feedback and tuning: power-on reset only
  logic roi_q;
  logic [2:0] slow_q;
  logic slow_en_q;
  logic [2:0] frc_post_q;
  logic [1:0] vco_div_q;
  logic [4:0] prescale_q;
  logic [8:0] fbd_q;
  logic [5:0] tune_q;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      roi_q <= 1'b0;
      slow_q <= OCC_SLOW_RESET; // R10
      frc_post_q <= OCC_FRC_POST_RESET;
      vco_div_q <= OCC_VCO_DIV_RESET;
      prescale_q <= OCC_PRESCALE_RESET;
    end else if (div_wr) begin
      roi_q <= reg_wdata_i[OCC_ROI_BIT];
      if (!slow_en_q) begin
        slow_q <= reg_wdata_i[OCC_SLOW_LSB +: 3]; // R12
      end
      frc_post_q <= reg_wdata_i[OCC_FRC_POST_LSB +: 3]; // R14
      if (reg_wdata_i[OCC_VCO_DIV_LSB +: 2] != OCC_VCO_DIV_RSVD) begin
        vco_div_q <= reg_wdata_i[OCC_VCO_DIV_LSB +: 2]; // R15
      end
      prescale_q <= reg_wdata_i[OCC_PRESCALE_LSB +: 5]; // R22
    end
  end

  // interrupt clear wins over a software set in the same cycle
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      slow_en_q <= 1'b0;
    end else if (roi_q && interrupt_i) begin
      slow_en_q <= 1'b0; // R9
    end else if (div_wr) begin
      slow_en_q <= reg_wdata_i[OCC_SLOW_EN_BIT] && slow_q != 3'h0; // R13
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      fbd_q <= OCC_FBD_RESET; // R16
      tune_q <= OCC_TUNE_RESET; // R8
    end else if (reg_write_i) begin
      if (reg_addr_i == OCC_ADDR_PLL_FBD) begin
        fbd_q <= reg_wdata_i[8:0]; // R16
      end
      if (reg_addr_i == OCC_ADDR_RC_TUNE) begin
        tune_q <= reg_wdata_i[5:0];
      end
    end
  end

  // =====================================================================
  // reference clock control: cleared by every reset
  logic sys_rst_n;
  logic ref_en_q;
  logic ref_slp_q;
  logic ref_sel_q;
  logic [3:0] ref_div_q;
  logic ref_run;
  logic ref_src_edge;
  logic slow_tick;

  assign sys_rst_n = rst_n && sys_reset_n_i;
  assign ref_run = ref_en_q && (!sleep_i || ref_slp_q); // R18

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_en_q <= 1'b0;
      ref_slp_q <= 1'b0;
      ref_sel_q <= 1'b0;
      ref_div_q <= 4'h0;
    end else if (!sys_rst_n) begin
      ref_en_q <= 1'b0;
      ref_slp_q <= 1'b0;
      ref_sel_q <= 1'b0;
      ref_div_q <= 4'h0;
    end else if (reg_write_i && reg_addr_i == OCC_ADDR_REF_CTRL) begin
      ref_en_q <= reg_wdata_i[OCC_REF_EN_BIT]; // R17
      ref_slp_q <= reg_wdata_i[OCC_REF_SLP_BIT];
      ref_sel_q <= reg_wdata_i[OCC_REF_SEL_BIT]; // R19
      ref_div_q <= reg_wdata_i[OCC_REF_DIV_LSB +: 4]; // R21
    end
  end

  // crystal source counts its rising edges; system source counts cycles
  assign ref_src_edge = ref_sel_q ? (xtal_level_q && !xtal_prev_q) : 1'b1; // R19

  logic [15:0] ref_count_q;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_count_q <= 16'h0000;
      reference_clock_pin_o <= 1'b0;
    end else if (!ref_run) begin
      ref_count_q <= 16'h0000;
      reference_clock_pin_o <= 1'b0; // R17
    end else if (ref_src_edge) begin
      if (ref_count_q >= 16'((32'h1 << ref_div_q) - 32'h1)) begin
        ref_count_q <= 16'h0000;
        reference_clock_pin_o <= ref_div_q == 4'h0 ? 1'b1 : !reference_clock_pin_o; // R20
      end else begin
        ref_count_q <= ref_count_q + 16'h0001;
      end
    end
  end
  occ_pow2_div #(
    .WIDTH(8)
  ) u_slow_div (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .run_i(1'b1),
    .sel_i(slow_en_q ? {1'b0, slow_q} : 4'h0), // R11
    .tick_o(slow_tick)
  );

  // =====================================================================
  // outputs and read port
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      secondary_osc_on_o <= 1'b0;
      active_source_o <= OCC_SRC_RESET;
      cpu_slow_tick_o <= 1'b0;
      fast_rc_postscale_o <= OCC_FRC_POST_RESET;
      vco_output_divider_o <= OCC_VCO_DIV_RESET;
      pll_input_prescale_o <= OCC_PRESCALE_RESET;
      pll_feedback_multiplier_o <= OCC_FBD_RESET;
      rc_trim_o <= OCC_TUNE_RESET;
    end else begin
      secondary_osc_on_o <= sec_osc_q; // R4
      active_source_o <= cur_src_q;
      cpu_slow_tick_o <= slow_tick; // R11
      fast_rc_postscale_o <= frc_post_q;
      vco_output_divider_o <= vco_div_q;
      pll_input_prescale_o <= prescale_q;
      pll_feedback_multiplier_o <= fbd_q;
      rc_trim_o <= tune_q;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 16'h0000;
    end else if (!reg_read_i) begin
      reg_rdata_o <= 16'h0000;
    end else begin
      case (reg_addr_i)
        OCC_ADDR_OSC_CTRL: reg_rdata_o <= {1'b0, cur_src_q, 1'b0, new_src_q, 2'b00, pll_lock_q,
            1'b0, clk_fail_q, 1'b0, sec_osc_q, switch_q};
        OCC_ADDR_CLK_DIV: reg_rdata_o <= {roi_q, slow_q, slow_en_q, frc_post_q, vco_div_q, 1'b0,
            prescale_q};
        OCC_ADDR_PLL_FBD: reg_rdata_o <= {7'h00, fbd_q};
        OCC_ADDR_RC_TUNE: reg_rdata_o <= {10'h000, tune_q};
        OCC_ADDR_REF_CTRL: reg_rdata_o <= {ref_en_q, 1'b0, ref_slp_q, ref_sel_q, ref_div_q, 8'h00};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end
  end

  // =====================================================================
  // checks
  locked_write_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R7
      (reg_write_i && reg_addr_i == OCC_ADDR_OSC_CTRL && !unlock_q) |=> $stable(new_src_q))
    else $error("locked oscillator control write took effect");
  unlock_once_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R25
      (reg_write_i && reg_addr_i == OCC_ADDR_OSC_CTRL) |=> !unlock_q)
    else $error("unlock window stayed open after a write");
  fail_set_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R2
      fail_event |=> clk_fail_q && osc_fail_trap_o)
    else $error("clock fail event not flagged");
  sequence switch_start_s;
    sw_state_q == OCC_SW_IDLE && osc_wr && reg_wdata_i[OCC_SWITCH_BIT];
  endsequence
  switch_done_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R5
      switch_start_s |=> switch_q ##[1:20] !switch_q)
    else $error("switch request did not complete");
  switch_src_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R24
      switch_done |=> cur_src_q == $past(new_src_q) && !switch_q)
    else $error("current source not updated on switch completion");
  roi_clear_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R9
      (roi_q && interrupt_i) |=> !slow_en_q)
    else $error("interrupt did not clear slowdown enable");
  ratio_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R12
      (slow_en_q && div_wr) |=> $stable(slow_q))
    else $error("ratio changed while slowdown enabled");
  zero_ratio_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R13
      (div_wr && slow_q == 3'h0 && !(roi_q && interrupt_i)) |=> !slow_en_q)
    else $error("slowdown enabled with zero ratio");
  vco_rsvd_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R15
      vco_div_q != OCC_VCO_DIV_RSVD)
    else $error("reserved vco divider code stored");
  ref_off_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R18
      (!ref_run) |=> !reference_clock_pin_o)
    else $error("reference pin active while disabled");
  lock_off_a: assert property (@(posedge clock_i) disable iff (!rst_n) // R1
      !pll_used |=> !pll_lock_q)
    else $error("lock reported with pll unused");
endmodule // occ_clock_config

// [logic/occ_pkg.sv]
package occ_pkg;
  // =====================================================================
  // register map (word addresses on the plain register port)
  localparam logic [3:0] OCC_ADDR_OSC_CTRL = 4'h0;
  localparam logic [3:0] OCC_ADDR_CLK_DIV = 4'h1;
  localparam logic [3:0] OCC_ADDR_PLL_FBD = 4'h2;
  localparam logic [3:0] OCC_ADDR_RC_TUNE = 4'h3;
  localparam logic [3:0] OCC_ADDR_REF_CTRL = 4'h4;
  localparam logic [3:0] OCC_ADDR_UNLOCK = 4'h5;
  localparam logic [15:0] OCC_UNLOCK_KEY = 16'h55AA;
  // =====================================================================
  // oscillator control fields
  localparam int OCC_CUR_SRC_LSB = 12;
  localparam int OCC_NEW_SRC_LSB = 8;
  localparam int OCC_PLL_LOCK_BIT = 5;
  localparam int OCC_CLK_FAIL_BIT = 3;
  localparam int OCC_SEC_OSC_BIT = 1;
  localparam int OCC_SWITCH_BIT = 0;
  // =====================================================================
  // clock divisor fields
  localparam int OCC_ROI_BIT = 15;
  localparam int OCC_SLOW_LSB = 12;
  localparam int OCC_SLOW_EN_BIT = 11;
  localparam int OCC_FRC_POST_LSB = 8;
  localparam int OCC_VCO_DIV_LSB = 6;
  localparam int OCC_PRESCALE_LSB = 0;
  localparam logic [2:0] OCC_SLOW_RESET = 3'h3;
  localparam logic [2:0] OCC_FRC_POST_RESET = 3'h0;
  localparam logic [1:0] OCC_VCO_DIV_RESET = 2'h1;
  localparam logic [1:0] OCC_VCO_DIV_RSVD = 2'h2;
  localparam logic [4:0] OCC_PRESCALE_RESET = 5'h00;
  localparam logic [8:0] OCC_FBD_RESET = 9'h030;
  localparam logic [5:0] OCC_TUNE_RESET = 6'h00;
  localparam logic [2:0] OCC_SRC_RESET = 3'h7;
  // =====================================================================
  // reference clock control fields
  localparam int OCC_REF_EN_BIT = 15;
  localparam int OCC_REF_SLP_BIT = 13;
  localparam int OCC_REF_SEL_BIT = 12;
  localparam int OCC_REF_DIV_LSB = 8;
  // =====================================================================
  // timing: switch settle time and pll start-up time
  localparam int OCC_CLK_MHZ = 250;
  localparam int OCC_SWITCH_NS = 40;
  localparam int OCC_SWITCH_CYC = (OCC_SWITCH_NS * OCC_CLK_MHZ + 999) / 1000;
  localparam int OCC_PLL_START_NS = 400;
  localparam int OCC_PLL_START_CYC = (OCC_PLL_START_NS * OCC_CLK_MHZ + 999) / 1000;

  typedef enum logic [2:0] {
    OCC_SRC_FRC, OCC_SRC_FRC_PLL, OCC_SRC_PRI, OCC_SRC_PRI_PLL,
    OCC_SRC_SEC, OCC_SRC_LPRC, OCC_SRC_FRC16, OCC_SRC_FRCN
  } occ_src_type;

  typedef enum {
    OCC_SW_IDLE, OCC_SW_WAIT
  } occ_sw_state_type;
endpackage

// [logic/occ_pow2_div.sv]
`timescale 1ns/1ps
// divide-by-2^n enable generator; tick_o pulses once every 2^sel_i cycles
module occ_pow2_div #(
  parameter int WIDTH = 15
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [3:0] sel_i,
  output logic tick_o
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] limit;

  assign limit = WIDTH'((32'h1 << sel_i) - 32'h1);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_q <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count_q <= '0;
      tick_o <= 1'b0;
    end else if (count_q >= limit) begin
      count_q <= '0;
      tick_o <= 1'b1;
    end else begin
      count_q <= count_q + WIDTH'(1);
      tick_o <= 1'b0;
    end
  end
endmodule // occ_pow2_div

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  import occ_pkg::*;
  // ====================
  // stimulus, outputs and bookkeeping
  localparam logic [3:0] OSC = OCC_ADDR_OSC_CTRL;
  localparam logic [3:0] CD = OCC_ADDR_CLK_DIV;
  localparam logic [3:0] FB = OCC_ADDR_PLL_FBD;
  localparam logic [3:0] TU = OCC_ADDR_RC_TUNE;
  localparam logic [3:0] RF = OCC_ADDR_REF_CTRL;
  logic clock_i = 1'b0, rst_n_i = 1'b0, sys_reset_n_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o, d;
  logic reg_write_i = 1'b0, reg_read_i = 1'b0, pll_locked_i = 1'b0, clock_fail_i = 1'b0;
  logic interrupt_i = 1'b0, sleep_i = 1'b0, crystal_clk_i = 1'b0, xtal_run = 1'b0, rd_pend = 1'b0;
  logic trap, sec_on, tick, pin;
  logic [2:0] src, frc_post;
  logic [1:0] vco;
  logic [4:0] pre;
  logic [8:0] fbd;
  logic [5:0] trim;
  logic [31:0] exp_q[$];
  int n_mismatch = 0, total_checks = 0, c;

  always #2 clock_i = ~clock_i;

  occ_clock_config dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .sys_reset_n_i(sys_reset_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .pll_locked_i(pll_locked_i),
    .clock_fail_i(clock_fail_i), .interrupt_i(interrupt_i), .sleep_i(sleep_i),
    .crystal_clk_i(crystal_clk_i), .osc_fail_trap_o(trap), .secondary_osc_on_o(sec_on),
    .active_source_o(src), .cpu_slow_tick_o(tick), .fast_rc_postscale_o(frc_post),
    .vco_output_divider_o(vco), .pll_input_prescale_o(pre), .pll_feedback_multiplier_o(fbd),
    .rc_trim_o(trim), .reference_clock_pin_o(pin));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ====================
  // register port master: every pause goes through cyc so strobes drop
  task automatic cyc(input int n);
    reg_write_i <= 1'b0;
    reg_read_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] dv);
    reg_addr_i <= a;
    reg_wdata_i <= dv;
    reg_write_i <= 1'b1;
    reg_read_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    exp_q.push_back({m, e});
    reg_addr_i <= a;
    reg_write_i <= 1'b0;
    reg_read_i <= 1'b1;
    @(posedge clock_i);
  endtask

  task automatic ow(input logic [15:0] dv);
    wr(OCC_ADDR_UNLOCK, OCC_UNLOCK_KEY);
    wr(OSC, dv);
  endtask

  task automatic bail();
    n_mismatch++;
    finish_test();
  endtask

  task automatic wait_trap();
    int i;
    for (i = 0; i < 12; i++) begin
      cyc(1);
      if (trap === 1'b1) break;
    end
    if (i == 12) bail();
    cyc(1);
    chk(16'(trap), 16'h0000);
  endtask

  task automatic wait_src(input logic [2:0] s);
    int i;
    for (i = 0; i < 40; i++) begin
      cyc(1);
      if (src === s) break;
    end
    if (i == 40) bail();
  endtask

  task automatic count(input bit use_pin, input int n);
    logic p;
    c = 0;
    p = pin;
    repeat (n) begin
      cyc(1);
      if (use_pin ? (pin === 1'b1 && p === 1'b0) : tick === 1'b1) c++;
      p = pin;
    end
  endtask

  task automatic intr();
    interrupt_i <= 1'b1;
    cyc(1);
    interrupt_i <= 1'b0;
    cyc(2);
  endtask

  task automatic chk_reset();
    rd(OSC, 16'h7700, 16'h772B);
    rd(CD, 16'h3040, 16'hFFFF);
    rd(FB, 16'h0030, 16'hFFFF);
    rd(TU, 16'h0000, 16'hFFFF);
    rd(RF, 16'h0000, 16'hFFFF);
    rd(4'h6, 16'h0000, 16'hFFFF);
    cyc(1);
    chk(16'(src), 16'h0007);
    chk(16'(vco), 16'h0001);
    chk(16'(fbd), 16'h0030);
  endtask

  // read data is compared one cycle after its strobe, oldest note first
  always @(posedge clock_i) begin
    rd_pend <= reg_read_i;
    if (rd_pend && exp_q.size() > 0) begin
      chk(reg_rdata_o & exp_q[0][31:16], exp_q[0][15:0]);
      void'(exp_q.pop_front());
    end
  end

  always @(posedge clock_i)
    if (xtal_run && $urandom_range(0, 2) == 0) crystal_clk_i <= ~crystal_clk_i;

  // ====================
  // scenarios
  initial begin
    void'($urandom(10342));
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    cyc(5);
    chk_reset();
    wr(OSC, 16'h0702);
    rd(OSC, 16'h0000, 16'h0002);
    ow(16'h0702);
    rd(OSC, 16'h0002, 16'h0002);
    wr(OSC, 16'h0700);
    rd(OSC, 16'h0002, 16'h0002);
    cyc(1);
    chk(16'(sec_on), 16'h0001);
    // source order keeps the two pll modes apart
    for (int k = 0; k < 8; k++) begin
      pll_locked_i <= (k == 1);
      if (k == 3) begin
        ow(16'h0003);
        wait_src(3'h0);
      end
      d = 16'((k << 12) | (k << 8) | 2);
      ow(d | 16'h0001);
      rd(OSC, 16'h0001, 16'h0001);
      wait_src(3'(k));
      rd(OSC, d | (k == 1 ? 16'h0020 : 16'h0000), 16'h772B);
      if (k == 3) begin
        cyc(110);
        rd(OSC, d | 16'h0020, 16'h772B);
      end
    end
    clock_fail_i <= 1'b1;
    wait_trap();
    rd(OSC, 16'h0008, 16'h0008);
    clock_fail_i <= 1'b0;
    ow(16'h0702);
    rd(OSC, 16'h0000, 16'h0008);
    ow(16'h070A);
    wait_trap();
    rd(OSC, 16'h0008, 16'h0008);
    ow(16'h0700);
    rd(OSC, 16'h0000, 16'h000A);
    cyc(2);
    chk(16'(sec_on), 16'h0000);
    wr(CD, 16'h0040);
    wr(CD, 16'h0840);
    rd(CD, 16'h0040, 16'hFFFF);
    count(0, 8);
    chk(16'(c), 16'h0008);
    wr(CD, 16'h2040);
    wr(CD, 16'h2840);
    rd(CD, 16'h2840, 16'hFFFF);
    cyc(8);
    count(0, 32);
    chk(16'(c), 16'h0008);
    wr(CD, 16'h5840);
    rd(CD, 16'h2840, 16'hFFFF);
    intr();
    rd(CD, 16'h2840, 16'hFFFF);
    wr(CD, 16'hA840);
    intr();
    rd(CD, 16'hA040, 16'hFFFF);
    wr(CD, 16'h7040);
    wr(CD, 16'h7840);
    cyc(130);
    count(0, 256);
    chk(16'(c), 16'h0002);
    wr(CD, 16'h7040);
    repeat (4) begin
      d = 16'($urandom) & 16'h77DF;
      if (d[7:6] == 2'h2) d[7:6] = 2'h3;
      wr(CD, d);
      wr(FB, d & 16'h01FF);
      wr(TU, {10'h000, d[15:10]});
      rd(CD, d, 16'hFFFF);
      rd(FB, d & 16'h01FF, 16'hFFFF);
      rd(TU, {10'h000, d[15:10]}, 16'hFFFF);
      chk(16'(frc_post), 16'(d[10:8]));
      chk(16'(vco), 16'(d[7:6]));
      chk(16'(pre), 16'(d[4:0]));
      chk(16'(fbd), d & 16'h01FF);
      chk(16'(trim), 16'(d[15:10]));
    end
    wr(FB, 16'hFFFF);
    rd(FB, 16'h01FF, 16'hFFFF);
    wr(CD, {d[15:8], 2'h2, d[5:0]});
    rd(CD, d, 16'hFFFF);
    wr(RF, 16'h8000);
    cyc(6);
    chk(16'(pin), 16'h0001);
    wr(RF, 16'h0000);
    wr(RF, 16'h0200);
    wr(RF, 16'h8200);
    cyc(16);
    count(1, 64);
    chk(16'(c), 16'h0008);
    sleep_i <= 1'b1;
    cyc(4);
    count(1, 32);
    chk(16'(c), 16'h0000);
    chk(16'(pin), 16'h0000);
    wr(RF, 16'h0000);
    wr(RF, 16'h2200);
    wr(RF, 16'hA200);
    cyc(16);
    count(1, 64);
    chk(16'(c), 16'h0008);
    sleep_i <= 1'b0;
    wr(RF, 16'h1100);
    wr(RF, 16'h9100);
    count(1, 40);
    chk(16'(c), 16'h0000);
    xtal_run <= 1'b1;
    count(1, 200);
    chk(16'(c > 3), 16'h0001);
    wr(RF, 16'h1100);
    cyc(6);
    chk(16'(pin), 16'h0000);
    wr(RF, 16'h9100);
    cyc(1);
    sys_reset_n_i <= 1'b0;
    cyc(2);
    sys_reset_n_i <= 1'b1;
    rd(RF, 16'h0000, 16'hFFFF);
    rd(CD, d, 16'hFFFF);
    rd(OSC, 16'h7700, 16'h772B);
    cyc(1);
    rst_n_i <= 1'b0;
    cyc(3);
    rst_n_i <= 1'b1;
    cyc(5);
    chk_reset();
    cyc(3);
    if (exp_q.size() != 0) n_mismatch++;
    finish_test();
  end

  initial begin
    #200000;
    bail();
  end
endmodule // tb
